// [rtl/sanc_pkg.sv]
/*
 package for the serial ack/nak transmit control: reply codes, modes,
 timing constants and the carriers shared between the main file, the checker and the bench.
 assumes a 100 MHz core clock.
*/
package sanc_pkg;
   // reply codes from the host
   localparam logic [7:0] SANC_ACK_CODE = 8'h06;
   localparam logic [7:0] SANC_NAK_CODE = 8'h15;
   localparam logic [7:0] SANC_DC1_CODE = 8'h11;

   // clock rate and times in their own unit
   localparam longint SANC_CLK_HZ = 100000000;
   localparam longint SANC_T_100MS = 100;
   localparam longint SANC_T_500MS = 500;
   localparam longint SANC_T_1000MS = 1000;
   localparam longint SANC_T_20MS = 20;
   localparam longint SANC_T_50MS = 50;
   localparam longint SANC_MS_CYC = SANC_CLK_HZ / 1000;

   // cycle counts derived from the times
   localparam longint SANC_CYC_100MS = SANC_T_100MS * SANC_MS_CYC;
   localparam longint SANC_CYC_500MS = SANC_T_500MS * SANC_MS_CYC;
   localparam longint SANC_CYC_1000MS = SANC_T_1000MS * SANC_MS_CYC;
   localparam longint SANC_CYC_20MS = SANC_T_20MS * SANC_MS_CYC;
   localparam longint SANC_CYC_50MS = SANC_T_50MS * SANC_MS_CYC;

   // bit rate and framing defaults
   localparam int SANC_BAUD_DEF = 9600;
   localparam int SANC_FIFO_DEPTH = 8;
   localparam int SANC_MSG_MAX = 256;

   // timeout select and gap select encodings, reset values
   typedef enum logic [1:0] {
      SANC_TO_UNLIM = 2'b00,
      SANC_TO_100 = 2'b01,
      SANC_TO_500 = 2'b10,
      SANC_TO_1000 = 2'b11
   } sanc_tosel_t;

   typedef enum logic [1:0] {
      SANC_GAP_OFF = 2'b00,
      SANC_GAP_20 = 2'b01,
      SANC_GAP_50 = 2'b10,
      SANC_GAP_100 = 2'b11
   } sanc_gapsel_t;

   typedef enum logic [1:0] {
      SANC_HS_NONE = 2'b00,
      SANC_HS_ACK = 2'b01,
      SANC_HS_ACK_NR = 2'b10
   } sanc_hs_t;

   typedef enum logic [1:0] {
      SANC_PAR_NONE = 2'b00,
      SANC_PAR_EVEN = 2'b01,
      SANC_PAR_ODD = 2'b10
   } sanc_par_t;

   // serial settings that take effect together on save
   typedef struct packed {
      sanc_hs_t hs;
      sanc_tosel_t tosel;
      sanc_gapsel_t gap;
      sanc_par_t par;
      logic data7;
      logic stop2;
      logic [15:0] bit_div;
   } sanc_cfg_t;

   localparam logic [15:0] SANC_DIV_DEF = 16'(SANC_CLK_HZ / SANC_BAUD_DEF);
   localparam sanc_cfg_t SANC_CFG_RST = '{hs: SANC_HS_NONE, tosel: SANC_TO_1000,
      gap: SANC_GAP_OFF, par: SANC_PAR_NONE, data7: 1'b0, stop2: 1'b0,
      bit_div: SANC_DIV_DEF};

   // end-of-transfer report
   typedef struct packed {
      logic done;
      logic good;
      logic err;
   } sanc_result_t;
endpackage

// [rtl/sanc_fifo.sv]
/*
 small message fifo with registered read data.
 assumes one clock; write is refused while full, read waits while empty.
*/
`timescale 1ns/100ps
module sanc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // filling side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // draining side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
      logic [WIDTH-1:0] rdata;
      logic rvalid;
      logic rdy;
   } sanc_fifo_st_t;

   logic [WIDTH-1:0] mem_q [DEPTH];
   sanc_fifo_st_t st_q, st_d;
   logic full, empty, push, pop;

   ////////////////////////////////////////////////////////////////////////
   // flags: pointers differ only in the wrap bit when full
   function automatic logic is_full(input logic [AW:0] w, input logic [AW:0] r);
      return (w[AW] != r[AW]) && (w[AW-1:0] == r[AW-1:0]);
   endfunction

   assign full = is_full(st_q.wp, st_q.rp);
   assign empty = (st_q.wp == st_q.rp);
   assign push = in_valid && !full;
   // prefetch into the output register whenever it is free or being taken
   assign pop = !empty && (!st_q.rvalid || out_ready);
   assign in_ready = st_q.rdy; // registered copy of not-full
   assign out_data = st_q.rdata;
   assign out_valid = st_q.rvalid;

   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.wp = st_q.wp + 1'b1;
      end
      if (out_ready) begin
         st_d.rvalid = 1'b0;
      end
      if (pop) begin
         st_d.rdata = mem_q[st_q.rp[AW-1:0]];
         st_d.rvalid = 1'b1;
         st_d.rp = st_q.rp + 1'b1;
      end
      // ready kept as a register so the port is not decoded
      st_d.rdy = !is_full(st_d.wp, st_d.rp);
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '{wp: '0, rp: '0, rdata: '0, rvalid: 1'b0, rdy: 1'b1};
      end else begin
         st_q <= st_d;
      end
   end

   // storage has no reset: contents are guarded by the pointers
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_q[st_q.wp[AW-1:0]] <= in_data;
      end
   end
endmodule

// [rtl/sanc_txctl.sv]
/*
 serial transmit with ack/nak reply control: message store, character
 framing, inter-character gap, reply wait with timeout and resend.
 assumes a host byte receiver on the same clock delivering rx_byte pulses,
 and that rxd/settings pins are handled elsewhere; one message at a time.
 limitation: a message longer than MSG_MAX bytes wraps the store index and
 is garbled, so the source must keep within it. a save pulse seen while a
 transfer runs is ignored; the staged values wait for a later save.
*/
// Function
// [R1] ack modes: wait one reply byte after message
// [R2] ack byte ends transfer with good-read
// [R3] nak byte resends message, waits again
// [R4] dc1 byte ends transfer silently
// [R5] plain ack timeout raises error indication
// [R6] timeout unlimited, 100ms, 500ms, 1s default
// [R7] no-response mode: 100ms silence means good
// [R8] gap after each character: 0/20/50/100ms
// [R9] new settings apply only after save command
// [R10] parity bit gives odd or even ones
// [R11] programmable bit rate and character format
// [R12] other bytes ignored, timeout keeps running
// [R13] resend from first character, timer restarts
`timescale 1ns/100ps
module sanc_txctl
   import sanc_pkg::*;
#(
   parameter longint TO_100_CYC = sanc_pkg::SANC_CYC_100MS,
   parameter longint TO_500_CYC = sanc_pkg::SANC_CYC_500MS,
   parameter longint TO_1000_CYC = sanc_pkg::SANC_CYC_1000MS,
   parameter longint GAP_20_CYC = sanc_pkg::SANC_CYC_20MS,
   parameter longint GAP_50_CYC = sanc_pkg::SANC_CYC_50MS,
   parameter int MSG_MAX = sanc_pkg::SANC_MSG_MAX
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // message input stream
   input wire logic [7:0] msg_data,
   input wire logic msg_valid,
   input wire logic msg_last,
   output logic msg_ready,
   // received host bytes, same clock
   input wire logic [7:0] rx_byte,
   input wire logic rx_valid,
   // pending settings and commands
   input wire sanc_pkg::sanc_cfg_t cfg_pending,
   input wire logic reply_timeout_unlimited_cmd,
   input wire logic reply_timeout_short_cmd,
   input wire logic reply_timeout_medium_cmd,
   input wire logic reply_timeout_long_cmd,
   input wire logic char_gap_off_cmd,
   input wire logic char_gap_small_cmd,
   input wire logic char_gap_mid_cmd,
   input wire logic char_gap_large_cmd,
   input wire logic save_settings_cmd,
   // serial line and results
   output logic txd,
   output logic busy,
   output sanc_pkg::sanc_result_t result,
   output sanc_pkg::sanc_cfg_t cfg_active
);
   import sanc_pkg::*;

   localparam int MW = $clog2(MSG_MAX);

   typedef enum logic [2:0] {
      ST_LOAD = 3'b000,
      ST_CHAR = 3'b001,
      ST_BIT = 3'b010,
      ST_GAP = 3'b011,
      ST_WAIT = 3'b100,
      ST_FETCH = 3'b101
   } sanc_st_e_t;

   // all state but the message store and its read register in one struct: one copy built below, registered in one place
   typedef struct packed {
      sanc_st_e_t st;
      sanc_cfg_t act;
      sanc_tosel_t to_shadow;
      sanc_gapsel_t gap_shadow;
      logic [MW-1:0] len;
      logic [MW-1:0] idx;
      logic [11:0] shreg;
      logic [3:0] nbits;
      logic [15:0] bcnt;
      logic [31:0] tcnt;
      logic txd;
      logic wr_ok;
      sanc_result_t res;
      logic busy;
   } sanc_state_t;

   localparam sanc_state_t ST_RST = '{st: ST_LOAD, act: SANC_CFG_RST,
      to_shadow: SANC_TO_1000, gap_shadow: SANC_GAP_OFF, len: '0, idx: '0,
      shreg: '0, nbits: '0, bcnt: '0, tcnt: '0, txd: 1'b1, wr_ok: 1'b0, res: '0,
      busy: 1'b0};

   sanc_state_t s_q, s_d;
   logic [7:0] msg_mem [MSG_MAX];
   logic [7:0] rd_q;
   logic [7:0] f_data;
   logic f_valid, f_last_q, f_ready;

   ////////////////////////////////////////////////////////////////////////
   // helpers
   // limits are cycle counts; the unlimited choice leaves the timer frozen in plain ack mode
   function automatic logic [31:0] to_limit(input sanc_tosel_t sel, input sanc_hs_t hs);
      if (hs == SANC_HS_ACK_NR) begin
         to_limit = 32'(TO_100_CYC); // [R7]
      end else begin
         case (sel) // [R6]
            SANC_TO_100: to_limit = 32'(TO_100_CYC);
            SANC_TO_500: to_limit = 32'(TO_500_CYC);
            SANC_TO_1000: to_limit = 32'(TO_1000_CYC);
            default: to_limit = '0;
         endcase
      end
   endfunction

   function automatic logic [31:0] gap_limit(input sanc_gapsel_t sel);
      case (sel) // [R8]
         SANC_GAP_20: gap_limit = 32'(GAP_20_CYC);
         SANC_GAP_50: gap_limit = 32'(GAP_50_CYC);
         SANC_GAP_100: gap_limit = 32'(TO_100_CYC);
         default: gap_limit = '0;
      endcase
   endfunction

   // frame: start, data lsb first, optional parity, stops; shifted out lsb first
   function automatic logic [11:0] frame(input logic [7:0] d, input sanc_cfg_t c);
      logic [7:0] dm;
      logic p;
      dm = c.data7 ? {1'b0, d[6:0]} : d;
      p = ^dm ^ (c.par == SANC_PAR_ODD); // [R10]
      frame = '1;
      if (c.data7) begin
         frame[7:0] = {dm[6:0], 1'b0};
         if (c.par != SANC_PAR_NONE) frame[8] = p;
      end else begin
         frame[8:0] = {dm, 1'b0};
         if (c.par != SANC_PAR_NONE) frame[9] = p;
      end
   endfunction

   function automatic logic [3:0] frame_len(input sanc_cfg_t c);
      frame_len = 4'd10 - {3'd0, c.data7} + {3'd0, c.par != SANC_PAR_NONE}
         + {3'd0, c.stop2}; // [R11]
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // message buffer in front of the store; its ready stalls the source
   sanc_fifo #(.WIDTH(9), .DEPTH(SANC_FIFO_DEPTH)) u_fifo (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .in_data({msg_last, msg_data}),
      .in_valid(msg_valid),
      .in_ready(msg_ready),
      .out_data({f_last_q, f_data}),
      .out_valid(f_valid),
      .out_ready(f_ready)
   );
   assign f_ready = (s_q.st == ST_LOAD);

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_d = s_q;
      s_d.wr_ok = 1'b0;
      s_d.res = '0;
      // staged settings, committed together on save
      if (reply_timeout_unlimited_cmd) s_d.to_shadow = SANC_TO_UNLIM;
      if (reply_timeout_short_cmd) s_d.to_shadow = SANC_TO_100;
      if (reply_timeout_medium_cmd) s_d.to_shadow = SANC_TO_500;
      if (reply_timeout_long_cmd) s_d.to_shadow = SANC_TO_1000;
      if (char_gap_off_cmd) s_d.gap_shadow = SANC_GAP_OFF;
      if (char_gap_small_cmd) s_d.gap_shadow = SANC_GAP_20;
      if (char_gap_mid_cmd) s_d.gap_shadow = SANC_GAP_50;
      if (char_gap_large_cmd) s_d.gap_shadow = SANC_GAP_100;
      // applied only between messages so framing never changes mid-transfer
      if (save_settings_cmd && s_q.st == ST_LOAD) begin
         s_d.act = cfg_pending; // [R9]
         s_d.act.tosel = s_q.to_shadow;
         s_d.act.gap = s_q.gap_shadow;
      end
      case (s_q.st)
         ST_LOAD: begin
            // fill the store; idx ends on the last byte, which becomes len
            if (f_valid) begin
               s_d.wr_ok = 1'b1;
               if (f_last_q) begin
                  s_d.len = s_q.idx;
                  s_d.idx = '0;
                  s_d.st = ST_FETCH;
               end else begin
                  s_d.idx = s_q.idx + 1'b1;
               end
            end
         end
         ST_FETCH: begin
            // one cycle for the store's registered read of the new idx
            s_d.st = ST_CHAR;
         end
         ST_CHAR: begin
            // rd_q holds msg_mem[idx] one cycle after idx settles
            s_d.shreg = frame(rd_q, s_q.act);
            s_d.nbits = frame_len(s_q.act);
            s_d.bcnt = s_q.act.bit_div;
            s_d.st = ST_BIT;
         end
         ST_BIT: begin
            // line bit lags the shift register by one register stage
            s_d.txd = s_q.shreg[0];
            if (s_q.bcnt > 16'd1) begin
               s_d.bcnt = s_q.bcnt - 1'b1;
            end else begin
               s_d.bcnt = s_q.act.bit_div;
               s_d.shreg = {1'b1, s_q.shreg[11:1]};
               s_d.nbits = s_q.nbits - 1'b1;
               if (s_q.nbits == 4'd1) begin
                  s_d.tcnt = gap_limit(s_q.act.gap);
                  s_d.st = ST_GAP;
               end
            end
         end
         ST_GAP: begin
            // gap also follows the last character, before the reply wait
            s_d.txd = 1'b1;
            if (s_q.tcnt != '0) begin
               s_d.tcnt = s_q.tcnt - 1'b1; // [R8]
            end else if (s_q.idx == s_q.len) begin
               s_d.tcnt = to_limit(s_q.act.tosel, s_q.act.hs); // [R13]
               s_d.st = (s_q.act.hs == SANC_HS_NONE) ? ST_LOAD : ST_WAIT; // [R1]
               s_d.idx = '0;
               s_d.res.done = (s_q.act.hs == SANC_HS_NONE);
            end else begin
               s_d.idx = s_q.idx + 1'b1;
               s_d.st = ST_FETCH;
            end
         end
         ST_WAIT: begin
            // a reply beats a timeout that ends in the same cycle
            if (rx_valid && rx_byte == SANC_ACK_CODE) begin
               s_d.res = '{done: 1'b1, good: 1'b1, err: 1'b0}; // [R2]
               s_d.st = ST_LOAD;
            end else if (rx_valid && rx_byte == SANC_DC1_CODE) begin
               s_d.res = '{done: 1'b1, good: 1'b0, err: 1'b0}; // [R4]
               s_d.st = ST_LOAD;
            end else if (rx_valid && rx_byte == SANC_NAK_CODE) begin
               // timer is reloaded when the resent message's last gap ends
               s_d.idx = '0; // [R3] [R13]
               s_d.st = ST_FETCH;
            end else if (s_q.act.tosel == SANC_TO_UNLIM && s_q.act.hs == SANC_HS_ACK) begin
               s_d.tcnt = s_q.tcnt; // [R6]
            end else if (s_q.tcnt > 32'd1) begin
               s_d.tcnt = s_q.tcnt - 1'b1; // [R12]
            end else begin
               s_d.st = ST_LOAD;
               s_d.res.done = 1'b1;
               s_d.res.good = (s_q.act.hs == SANC_HS_ACK_NR); // [R7]
               s_d.res.err = (s_q.act.hs == SANC_HS_ACK); // [R5]
            end
         end
         default: s_d.st = ST_LOAD;
      endcase
      // busy from the next state so the port is a plain register bit
      s_d.busy = (s_d.st != ST_LOAD);
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   // reset values are constants only; the whole struct loads at once
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // message store with registered read, so a nak can replay it
   always_ff @(posedge core_clk) begin
      if (f_ready && f_valid) begin
         msg_mem[s_q.idx] <= f_data;
      end
      rd_q <= msg_mem[s_q.idx];
   end

   // ports come straight from state register bits
   assign txd = s_q.txd;
   assign busy = s_q.busy;
   assign result = s_q.res;
   assign cfg_active = s_q.act;
endmodule

// [sim/sanc_txctl_props.sv]
/*
 checker for the ack/nak transmit control, bound to its ports.
 assumes result is a registered one-cycle pulse and one clock domain.
*/
`timescale 1ns/100ps
module sanc_txctl_chk
   import sanc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // watched ports
   input wire logic [7:0] rx_byte,
   input wire logic rx_valid,
   input wire logic save_settings_cmd,
   input wire logic txd,
   input wire logic busy,
   input wire sanc_pkg::sanc_result_t result,
   input wire sanc_pkg::sanc_cfg_t cfg_active
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////////////
   // line and result framing
   idle_line_a: assert property (!busy |-> txd)
      else $error("line low while idle");
   done_pulse_a: assert property (result.done |=> !result.done)
      else $error("done longer than one cycle");
   done_in_xfer_a: assert property (result.done |-> $past(busy))
      else $error("done without a transfer");
   flags_need_done_a: assert property ((result.good || result.err) |-> result.done)
      else $error("flag without done");
   good_or_err_a: assert property (result.done |-> !(result.good && result.err))
      else $error("good and error together");
   ////////////////////////////////////////////////////////////////////////////////
   // reply codes; ignoring junk keeps these antecedents tied to the code seen
   ack_good_a: assert property ($past(rx_valid && rx_byte == SANC_ACK_CODE) && result.done
      |-> result.good && !result.err) else $error("ack did not give good");
   dc1_silent_a: assert property ($past(rx_valid && rx_byte == SANC_DC1_CODE) && result.done
      |-> !result.good && !result.err) else $error("dc1 end not silent");
   no_resp_good_a: assert property (result.done && cfg_active.hs == SANC_HS_ACK_NR
      |-> !result.err) else $error("error in no-response mode");
   err_plain_a: assert property (result.err
      |-> cfg_active.hs == SANC_HS_ACK && cfg_active.tosel != SANC_TO_UNLIM)
      else $error("error with unlimited or wrong mode");
   // settings move only after a save taken while idle
   cfg_commit_a: assert property (!$stable(cfg_active)
      |-> $past(save_settings_cmd) && !$past(busy))
      else $error("settings changed without save");
endmodule
bind sanc_txctl sanc_txctl_chk u_chk (.core_clk(core_clk), .reset_n(reset_n),
   .rx_byte(rx_byte), .rx_valid(rx_valid), .save_settings_cmd(save_settings_cmd),
   .txd(txd), .busy(busy), .result(result), .cfg_active(cfg_active));

// [sim/sanc_host_model.sv]
/*
 host model: receives 8-data-bit characters from the line, sends one-byte replies.
 assumes a fixed bit divider handed in and replies started by the bench.
*/
`timescale 1ns/100ps
module sanc_host_model (
   // clock and line
   input wire logic core_clk,
   input wire logic txd,
   input wire logic [15:0] bit_div,
   // replies toward the device
   output logic [7:0] rx_byte,
   output logic rx_valid
);
   logic [7:0] got_q[$];
   logic pb_q[$];
   longint t_q[$];
   logic [7:0] ch;
   longint ts;
   ////////////////////////////////////////////////////////////////////////////////
   // sample mid-bit, lsb first; start times kept for gap checks
   initial begin
      rx_byte = 8'h5a;
      rx_valid = 1'b0;
      forever begin
         @(negedge txd);
         ts = $time;
         repeat (bit_div / 2) @(posedge core_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (bit_div) @(posedge core_clk);
            ch[i] = txd;
         end
         // bit after the data: parity if framed with one, else the first stop
         repeat (bit_div) @(posedge core_clk);
         pb_q.push_back(txd);
         got_q.push_back(ch);
         t_q.push_back(ts);
      end
   end
   // one reply byte per call; released byte goes inverted so nothing stale matches
   task automatic reply(input logic [7:0] code);
      @(posedge core_clk);
      rx_byte <= code;
      rx_valid <= 1'b1;
      @(posedge core_clk);
      rx_valid <= 1'b0;
      rx_byte <= ~code;
   endtask
endmodule

// [sim/tb_top.sv]
/*
 bench for the ack/nak transmit control with a queue model of expected output.
 assumes short sim timing: 100ms=200, 500ms=500, 1s=1000, 20ms=40, 50ms=100 cycles.
*/
`timescale 1ns/100ps
module tb_top;
   import sanc_pkg::*;
   logic core_clk, reset_n, msg_valid, msg_last, msg_ready, txd, busy, rx_valid;
   logic [7:0] msg_data, rx_byte;
   logic [8:0] cmd;
   logic [31:0] rng;
   sanc_cfg_t cfg_pending, cfg_active;
   sanc_result_t result;
   int miscompares, n_checks, gap_cyc, mlen, cnt, fbits;
   logic [7:0] exp_q[$];
   ////////////////////////////////////////////////////////////////////////////////
   sanc_txctl #(.TO_100_CYC(200), .TO_500_CYC(500), .TO_1000_CYC(1000), .GAP_20_CYC(40),
      .GAP_50_CYC(100)) u_dut (.core_clk(core_clk), .reset_n(reset_n), .msg_data(msg_data),
      .msg_valid(msg_valid), .msg_last(msg_last), .msg_ready(msg_ready), .rx_byte(rx_byte),
      .rx_valid(rx_valid), .cfg_pending(cfg_pending), .reply_timeout_unlimited_cmd(cmd[0]),
      .reply_timeout_short_cmd(cmd[1]), .reply_timeout_medium_cmd(cmd[2]),
      .reply_timeout_long_cmd(cmd[3]), .char_gap_off_cmd(cmd[4]), .char_gap_small_cmd(cmd[5]),
      .char_gap_mid_cmd(cmd[6]), .char_gap_large_cmd(cmd[7]), .save_settings_cmd(cmd[8]),
      .txd(txd), .busy(busy), .result(result), .cfg_active(cfg_active));
   sanc_host_model u_host (.core_clk(core_clk), .txd(txd), .bit_div(cfg_pending.bit_div),
      .rx_byte(rx_byte), .rx_valid(rx_valid));
   ////////////////////////////////////////////////////////////////////////////////
   // compare and report helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // bit after the data: even or odd count of ones with parity, else a stop bit
   function automatic logic exp_pb(input logic [7:0] b);
      case (cfg_pending.par)
         SANC_PAR_EVEN: return ^b;
         SANC_PAR_ODD: return ~^b;
         default: return 1'b1;
      endcase
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_res(input sanc_result_t got, input sanc_result_t exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t result %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // stimulus tasks; cmd index 0..3 timeout, 4..7 gap, 8 save
   task automatic pulse(input int i);
      @(posedge core_clk);
      cmd <= 9'h001 << i;
      @(posedge core_clk);
      cmd <= 9'h000;
   endtask
   task automatic setup(input sanc_hs_t hs, input int t, input int g, input int gc);
      sanc_cfg_t old;
      old = cfg_active;
      pulse(t);
      cfg_pending.hs <= hs;
      pulse(4 + g);
      repeat (3) @(posedge core_clk);
      chk(32'(cfg_active), 32'(old));
      pulse(8);
      repeat (2) @(negedge core_clk);
      chk(32'(cfg_active.hs), 32'(hs));
      chk(32'(cfg_active.tosel), 32'(t));
      chk(32'(cfg_active.gap), 32'(g));
      gap_cyc = gc;
   endtask
   task automatic send(input int n);
      @(posedge core_clk);
      mlen = n;
      for (int i = 0; i < n; i++) begin
         rng = xs(rng);
         exp_q.push_back(rng[7:0]);
         msg_data <= rng[7:0];
         msg_valid <= 1'b1;
         msg_last <= (i == n - 1);
         @(negedge core_clk);
         for (int k = 0; k < 50 && msg_ready !== 1'b1; k++) @(negedge core_clk);
         if (msg_ready !== 1'b1) begin
            miscompares++;
            end_of_test;
         end
         @(posedge core_clk);
      end
      msg_valid <= 1'b0;
      msg_last <= 1'b0;
   endtask
   // bytes seen by the host against the model, with start-to-start spacing
   task automatic chars;
      longint d, lo;
      for (int k = 0; k < 20000 && u_host.got_q.size() < exp_q.size(); k++) begin
         @(posedge core_clk);
      end
      if (u_host.got_q.size() < exp_q.size()) begin
         miscompares++;
         end_of_test;
      end
      for (int i = 0; i < exp_q.size(); i++) begin
         chk(32'(u_host.got_q[i]), 32'(exp_q[i]));
         chk(32'(u_host.pb_q[i]), 32'(exp_pb(exp_q[i])));
         // start-to-start: frame bits of 8 cycles, the gap, a few turn-around cycles
         if (i % mlen != 0) begin
            d = u_host.t_q[i] - u_host.t_q[i - 1];
            lo = (fbits * 8 + gap_cyc) * 10;
            chk(32'(d >= lo && d <= lo + 40), 1);
         end
      end
   endtask
   task automatic rep(input logic [7:0] code);
      repeat (gap_cyc + 10) @(posedge core_clk);
      u_host.reply(code);
   endtask
   task automatic wait_done(input int lo, input int hi, input logic [2:0] exp);
      int k;
      k = 0;
      while (result.done !== 1'b1 && k <= hi) begin
         @(negedge core_clk);
         k++;
      end
      chk(32'(k >= lo && k <= hi), 1);
      chk_res(result, sanc_result_t'(exp));
      if (k > hi) end_of_test;
      u_host.got_q.delete();
      u_host.t_q.delete();
      u_host.pb_q.delete();
      exp_q.delete();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // scenarios in order; each ends idle so the next save is taken
   initial begin
      reset_n = 1'b0;
      {msg_valid, msg_last, msg_data, cmd} = '0;
      {miscompares, n_checks, gap_cyc, mlen} = '0;
      fbits = 10;
      rng = 32'haa7d;
      cfg_pending = SANC_CFG_RST;
      cfg_pending.bit_div = 16'h0008;
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      @(negedge core_clk);
      chk(32'(cfg_active), 32'(SANC_CFG_RST));
      chk(32'(txd), 1);
      setup(SANC_HS_ACK, 1, 1, 40);
      send(3);
      chars;
      rep(8'h41);
      rep(SANC_ACK_CODE);
      wait_done(1, 8, 3'b110);
      send(2);
      chars;
      rep(SANC_NAK_CODE);
      for (int i = 0; i < 2; i++) exp_q.push_back(exp_q[i]);
      chars;
      wait_done(240, 256, 3'b101);
      send(1);
      chars;
      rep(SANC_DC1_CODE);
      wait_done(1, 8, 3'b100);
      setup(SANC_HS_ACK, 2, 2, 100);
      send(1);
      chars;
      wait_done(600, 616, 3'b101);
      setup(SANC_HS_ACK, 0, 0, 0);
      send(2);
      chars;
      cnt = 0;
      repeat (1500) @(negedge core_clk) cnt += int'(result.done === 1'b1);
      chk(32'(cnt), 0);
      rep(SANC_ACK_CODE);
      wait_done(1, 8, 3'b110);
      setup(SANC_HS_ACK_NR, 3, 3, 200);
      send(2);
      chars;
      wait_done(400, 416, 3'b110);
      // odd parity, two stops, no handshake: done one cycle after the last gap
      cfg_pending.par <= SANC_PAR_ODD;
      cfg_pending.stop2 <= 1'b1;
      fbits = 12;
      setup(SANC_HS_NONE, 3, 0, 0);
      send(2);
      chars;
      wait_done(14, 26, 3'b100);
      end_of_test;
   end
endmodule
